// *** hw/dpo_pkg.sv ***
package dpo_pkg;

  // ********************************************************
  // Register offsets
  // ********************************************************
  localparam logic [7:0] OFS_A_SEL = 8'h1a;
  localparam logic [7:0] OFS_A_LINK = 8'h1b;
  localparam logic [7:0] OFS_B_SEL = 8'h1c;
  localparam logic [7:0] OFS_B_LINK = 8'h1d;
  localparam logic [7:0] OFS_CLK = 8'h1e;

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int BIT_PORT_EN = 7;
  localparam int BIT_CHAN_MODE = 0;
  localparam int BIT_SEL_LSB = 1;
  localparam int BIT_CONC = 5;
  localparam int BIT_MASTER = 0;
  localparam int DIV_LSB = 1;
  localparam int STAT_REQ_A = 7;
  localparam int STAT_REQ_B = 6;

  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic [7:0] RST_SEL = 8'h00;
  localparam logic [7:0] RST_LINK = 8'h00;
  localparam logic [2:0] RST_CLK = 3'h0;

  // ********************************************************
  // Sizes
  // ********************************************************
  localparam int DATA_W = 16;
  localparam int GAIN_W = 12;
  localparam int NUM_CH = 4;
  localparam int NUM_SRC = 6;
  localparam int WORD_W = 19;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] SIGNAL_STRENGTH_WORD_PAD = 4'h0;

  // ********************************************************
  // Word serialiser states
  // ********************************************************
  typedef enum logic [1:0] {
    SER_IDLE,
    SER_Q,
    SER_SIGNAL_STRENGTH_WORD
  } dpo_ser_t;

endpackage

// *** hw/dpo_fifo.sv ***
`timescale 1ns/1ps
module dpo_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 8
) (
  // Clock, enable and reset
  input wire logic mclk,
  input wire logic ce,
  input wire logic rstn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic more
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic valid_ff;
  logic [WIDTH-1:0] data_ff;
  logic push;
  logic load;
  logic fetch;

  // The head word sits in a register so the pins see flop outputs.
  assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign load = !valid_ff || out_ready;
  assign fetch = load && (cnt_ff != '0);
  assign out_valid = valid_ff;
  assign out_data = data_ff;
  assign more = (cnt_ff != '0);

  always_ff @(posedge mclk) begin
    if (ce && push) begin
      mem[wr_ff] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else if (ce) begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
      end
      if (fetch) begin
        rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(fetch);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      valid_ff <= 1'b0;
      data_ff <= '0;
    end else if (ce && load) begin
      valid_ff <= fetch;
      if (fetch) begin
        data_ff <= mem[rd_ff];
      end
    end
  end

endmodule

// *** hw/dpo_top.sv ***
`timescale 1ns/1ps
module dpo_top #(
  parameter int FIFO_DEPTH = dpo_pkg::FIFO_DEPTH
) (
  // Clock, enable and reset
  input wire logic mclk,
  input wire logic ce,
  input wire logic rstn,
  // Configuration access
  input wire logic cfg_access_en,
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  // Channel filter samples
  input wire logic [3:0] ch_valid,
  input wire logic [63:0] ch_i,
  input wire logic [63:0] ch_q,
  // AGC samples
  input wire logic [1:0] agc_valid,
  input wire logic [31:0] agc_i,
  input wire logic [31:0] agc_q,
  input wire logic [23:0] agc_gain,
  // Port clock pin
  input wire logic pclk_in,
  output logic pclk_out,
  output logic pclk_oe,
  // Port A
  input wire logic port_a_acknowledge,
  output logic port_a_request,
  output logic [15:0] port_a_data_bus,
  output logic port_a_iq_flag,
  output logic [1:0] port_a_source_id,
  output logic port_a_parallel_active,
  // Port B
  input wire logic port_b_acknowledge,
  output logic port_b_request,
  output logic [15:0] port_b_data_bus,
  output logic port_b_iq_flag,
  output logic [1:0] port_b_source_id,
  output logic port_b_parallel_active
);

  localparam int DW = dpo_pkg::DATA_W;
  localparam int GW = dpo_pkg::GAIN_W;
  localparam int WW = dpo_pkg::WORD_W;
  localparam int NS = dpo_pkg::NUM_SRC;

  // ********************************************************
  // Configuration registers
  // ********************************************************
  logic [7:0] sel_ff [0:1];
  logic [7:0] link_ff [0:1];
  logic [2:0] clk_ff;
  logic [7:0] rdata_ff;
  logic [1:0] req_ff;
  logic cfg_hit;

  // Access opens only once the host has enabled it.
  assign cfg_hit = ce && cfg_access_en;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sel_ff[0] <= dpo_pkg::RST_SEL;
      sel_ff[1] <= dpo_pkg::RST_SEL;
      link_ff[0] <= dpo_pkg::RST_LINK;
      link_ff[1] <= dpo_pkg::RST_LINK;
      clk_ff <= dpo_pkg::RST_CLK;
    end else if (cfg_hit && cfg_wr) begin
      if (cfg_addr == dpo_pkg::OFS_A_SEL) begin
        sel_ff[0] <= cfg_wdata;
      end else if (cfg_addr == dpo_pkg::OFS_A_LINK) begin
        link_ff[0] <= cfg_wdata;
      end else if (cfg_addr == dpo_pkg::OFS_B_SEL) begin
        sel_ff[1] <= cfg_wdata;
      end else if (cfg_addr == dpo_pkg::OFS_B_LINK) begin
        link_ff[1] <= cfg_wdata;
      end else if (cfg_addr == dpo_pkg::OFS_CLK) begin
        clk_ff <= cfg_wdata[2:0];
      end
    end
  end

  // The clock register's upper bits report each port's request level.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata_ff <= 8'h00;
    end else if (cfg_hit && cfg_rd) begin
      if (cfg_addr == dpo_pkg::OFS_A_SEL) begin
        rdata_ff <= sel_ff[0];
      end else if (cfg_addr == dpo_pkg::OFS_A_LINK) begin
        rdata_ff <= link_ff[0];
      end else if (cfg_addr == dpo_pkg::OFS_B_SEL) begin
        rdata_ff <= sel_ff[1];
      end else if (cfg_addr == dpo_pkg::OFS_B_LINK) begin
        rdata_ff <= link_ff[1];
      end else if (cfg_addr == dpo_pkg::OFS_CLK) begin
        rdata_ff <= {req_ff[0], req_ff[1], 3'h0, clk_ff};
      end else begin
        rdata_ff <= 8'h00;
      end
    end
  end

  assign cfg_rdata = rdata_ff;

  // ********************************************************
  // Port clock: master divider or synchronised slave pin
  // ********************************************************
  logic master;
  logic [3:0] div_n;
  logic [3:0] half;
  logic [2:0] div_cnt_ff;
  logic [2:0] nxt_div_cnt;
  logic pclk_o_ff;
  logic pclk_s1_ff;
  logic pclk_s2_ff;
  logic pclk_s3_ff;
  logic rise;
  logic fall;

  assign master = clk_ff[dpo_pkg::BIT_MASTER];
  assign div_n = 4'h1 << clk_ff[dpo_pkg::DIV_LSB +: 2];
  assign half = div_n >> 1;
  assign nxt_div_cnt = ({1'b0, div_cnt_ff} + 4'h1 == div_n) ? 3'h0 :
                       div_cnt_ff + 3'h1;

  // At divide by one the pin stays high; events still fire every cycle.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      div_cnt_ff <= 3'h0;
      pclk_o_ff <= 1'b0;
    end else if (ce) begin
      div_cnt_ff <= master ? nxt_div_cnt : 3'h0;
      pclk_o_ff <= master && ((div_n == 4'h1) ||
                   ({1'b0, nxt_div_cnt} < half));
    end
  end

  // The slave pin may be asynchronous, so it is resynchronised first.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pclk_s1_ff <= 1'b0;
      pclk_s2_ff <= 1'b0;
      pclk_s3_ff <= 1'b0;
    end else if (ce) begin
      pclk_s1_ff <= pclk_in;
      pclk_s2_ff <= pclk_s1_ff;
      pclk_s3_ff <= pclk_s2_ff;
    end
  end

  assign rise = master ? (div_cnt_ff == 3'h0) :
                (pclk_s2_ff && !pclk_s3_ff);
  assign fall = master ? ({1'b0, div_cnt_ff} == half) :
                (!pclk_s2_ff && pclk_s3_ff);
  assign pclk_out = pclk_o_ff;
  assign pclk_oe = master;

  // ********************************************************
  // Holding slots shared by both ports
  // ********************************************************
  logic [DW-1:0] hold_i_ff [0:NS-1];
  logic [DW-1:0] hold_q_ff [0:NS-1];
  logic [GW-1:0] gain_ff [0:1];
  logic [1:0] gchg_ff;
  logic [NS-1:0] src_valid;

  assign src_valid = {agc_valid, ch_valid};

  // A slot is replaced only by its own source.
  for (genvar s = 0; s < NS; s++) begin : g_hold
    always_ff @(posedge mclk) begin
      if (!rstn) begin
        hold_i_ff[s] <= '0;
        hold_q_ff[s] <= '0;
      end else if (ce && src_valid[s]) begin
        if (s < dpo_pkg::NUM_CH) begin
          hold_i_ff[s] <= ch_i[(s % 4)*DW +: DW];
          hold_q_ff[s] <= ch_q[(s % 4)*DW +: DW];
        end else begin
          hold_i_ff[s] <= agc_i[(s % 2)*DW +: DW];
          hold_q_ff[s] <= agc_q[(s % 2)*DW +: DW];
        end
      end
    end
  end

  // Channel pairing into each AGC is done upstream.
  for (genvar a = 0; a < 2; a++) begin : g_gain
    always_ff @(posedge mclk) begin
      if (!rstn) begin
        gain_ff[a] <= '0;
        gchg_ff[a] <= 1'b0;
      end else if (ce && agc_valid[a]) begin
        gain_ff[a] <= agc_gain[a*GW +: GW];
        gchg_ff[a] <= (agc_gain[a*GW +: GW] != gain_ff[a]);
      end
    end
  end

  // ********************************************************
  // Per-port selection, serialiser and output stage
  // ********************************************************
  logic [DW-1:0] pdata_ff [0:1];
  logic [1:0] piq_ff;
  logic [1:0] pid_ff [0:1];
  logic [1:0] ack_s1_ff;
  logic [1:0] ack_s2_ff;
  logic [1:0] ack_smp_ff;
  logic [1:0] ack_pin;
  logic [1:0] en;

  assign ack_pin = {port_b_acknowledge, port_a_acknowledge};

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ack_s1_ff <= 2'h0;
      ack_s2_ff <= 2'h0;
      ack_smp_ff <= 2'h0;
    end else if (ce) begin
      ack_s1_ff <= ack_pin;
      ack_s2_ff <= ack_s1_ff;
      if (fall) begin
        ack_smp_ff <= ack_s2_ff;
      end
    end
  end

  for (genvar p = 0; p < 2; p++) begin : g_port
    logic chan_mode;
    logic conc;
    logic [NS-1:0] cap;
    logic [NS-1:0] take;
    logic [NS-1:0] pend_ff;
    logic [2:0] pick;
    logic any;
    dpo_pkg::dpo_ser_t st_ff;
    dpo_pkg::dpo_ser_t nxt_st;
    logic [DW-1:0] lat_q_ff;
    logic lat_signal_strength_word_ff;
    logic [GW-1:0] lat_gain_ff;
    logic [1:0] lat_id_ff;
    logic push_v;
    logic push_r;
    logic [WW-1:0] push_w;
    logic fo_v;
    logic fo_more;
    logic [WW-1:0] fo_w;
    logic pop;

    assign en[p] = link_ff[p][dpo_pkg::BIT_PORT_EN];
    assign chan_mode = link_ff[p][dpo_pkg::BIT_CHAN_MODE];
    assign conc = sel_ff[p][dpo_pkg::BIT_CONC];

    always_comb begin
      cap = '0;
      for (int s = 0; s < NS; s++) begin
        if (s < dpo_pkg::NUM_CH) begin
          cap[s] = chan_mode &&
                   sel_ff[p][dpo_pkg::BIT_SEL_LSB + s];
        end else begin
          cap[s] = !chan_mode &&
                   sel_ff[p][dpo_pkg::BIT_SEL_LSB + s % 4];
        end
        cap[s] = cap[s] && src_valid[s];
      end
    end

    // Lowest source number wins when several are waiting.
    always_comb begin
      pick = 3'h0;
      for (int s = NS - 1; s >= 0; s--) begin
        if (pend_ff[s]) begin
          pick = 3'(s);
        end
      end
    end

    assign any = |pend_ff;

    always_comb begin
      nxt_st = st_ff;
      take = '0;
      push_v = 1'b0;
      push_w = '0;
      case (st_ff)
        dpo_pkg::SER_IDLE: begin
          push_v = any;
          if (chan_mode && conc) begin
            push_w = {pick[1:0], 1'b1, hold_i_ff[pick][DW-1 -: 8],
                      hold_q_ff[pick][DW-1 -: 8]};
          end else if (chan_mode) begin
            push_w = {pick[1:0], 1'b1, hold_i_ff[pick]};
          end else begin
            push_w = {1'b0, pick == 3'h5, 1'b1,
                      hold_i_ff[pick]};
          end
          if (any && push_r) begin
            take[pick] = 1'b1;
            nxt_st = (chan_mode && conc) ? dpo_pkg::SER_IDLE :
                     dpo_pkg::SER_Q;
          end
        end
        dpo_pkg::SER_Q: begin
          push_v = 1'b1;
          push_w = {lat_id_ff, 1'b0, lat_q_ff};
          if (push_r) begin
            nxt_st = lat_signal_strength_word_ff ? dpo_pkg::SER_SIGNAL_STRENGTH_WORD :
                     dpo_pkg::SER_IDLE;
          end
        end
        dpo_pkg::SER_SIGNAL_STRENGTH_WORD: begin
          push_v = 1'b1;
          push_w = {1'b1, lat_id_ff[0], 1'b0, ~lat_gain_ff,
                    dpo_pkg::SIGNAL_STRENGTH_WORD_PAD};
          if (push_r) begin
            nxt_st = dpo_pkg::SER_IDLE;
          end
        end
        default: begin
          nxt_st = dpo_pkg::SER_IDLE;
        end
      endcase
    end

    // A new sample arriving as its slot is taken stays pending.
    always_ff @(posedge mclk) begin
      if (!rstn) begin
        pend_ff <= '0;
      end else if (ce) begin
        pend_ff <= en[p] ? (cap | (pend_ff & ~take)) : '0;
      end
    end

    always_ff @(posedge mclk) begin
      if (!rstn) begin
        st_ff <= dpo_pkg::SER_IDLE;
        lat_q_ff <= '0;
        lat_signal_strength_word_ff <= 1'b0;
        lat_gain_ff <= '0;
        lat_id_ff <= 2'h0;
      end else if (ce) begin
        st_ff <= en[p] ? nxt_st : dpo_pkg::SER_IDLE;
        if (|take) begin
          lat_q_ff <= hold_q_ff[pick];
          lat_id_ff <= chan_mode ? pick[1:0] : {1'b0, pick == 3'h5};
          lat_signal_strength_word_ff <= !chan_mode && gchg_ff[pick[0]];
          lat_gain_ff <= gain_ff[pick[0]];
        end
      end
    end

    // The queue rides out a slow acknowledge; disabling flushes stale words.
    dpo_fifo #(
      .WIDTH(WW),
      .DEPTH(FIFO_DEPTH)
    ) u_fifo (
      .mclk(mclk),
      .ce(ce),
      .rstn(rstn && en[p]),
      .in_valid(push_v),
      .in_ready(push_r),
      .in_data(push_w),
      .out_valid(fo_v),
      .out_ready(pop),
      .out_data(fo_w),
      .more(fo_more)
    );

    assign pop = rise && req_ff[p] && ack_smp_ff[p] && fo_v;

    always_ff @(posedge mclk) begin
      if (!rstn) begin
        req_ff[p] <= 1'b0;
        pdata_ff[p] <= '0;
        piq_ff[p] <= 1'b0;
        pid_ff[p] <= 2'h0;
      end else if (ce) begin
        if (!en[p]) begin
          req_ff[p] <= 1'b0;
          pdata_ff[p] <= '0;
          piq_ff[p] <= 1'b0;
        end else if (rise) begin
          req_ff[p] <= (fo_v && !pop) || fo_more || any ||
                       (st_ff != dpo_pkg::SER_IDLE);
          piq_ff[p] <= pop && fo_w[DW];
          if (pop) begin
            pdata_ff[p] <= fo_w[DW-1:0];
            pid_ff[p] <= fo_w[WW-1 -: 2];
          end
        end
      end
    end
  end

  // ********************************************************
  // Pin assignment
  // ********************************************************
  assign port_a_request = req_ff[0];
  assign port_a_data_bus = pdata_ff[0];
  assign port_a_iq_flag = piq_ff[0];
  assign port_a_source_id = pid_ff[0];
  assign port_a_parallel_active = en[0];
  assign port_b_request = req_ff[1];
  assign port_b_data_bus = pdata_ff[1];
  assign port_b_iq_flag = piq_ff[1];
  assign port_b_source_id = pid_ff[1];
  assign port_b_parallel_active = en[1];

endmodule

// *** tb/dpo_top_sva.sv ***
`timescale 1ns/1ps
module dpo_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Configuration writes
  input wire logic cfg_access_en,
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_wdata,
  // Port clock pin
  input wire logic pclk_out,
  input wire logic pclk_oe,
  // Port A
  input wire logic port_a_acknowledge,
  input wire logic port_a_request,
  input wire logic [15:0] port_a_data_bus,
  input wire logic port_a_iq_flag,
  input wire logic [1:0] port_a_source_id,
  input wire logic port_a_parallel_active
);
  // ****************************************
  // Shadow of the mode bits
  // ****************************************
  logic conc_ff;
  logic chan_ff;
  logic [2:0] ctl_ff;
  logic wr_ok;
  assign wr_ok = cfg_access_en && cfg_wr;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      conc_ff <= 1'b0;
      chan_ff <= 1'b0;
      ctl_ff <= 3'h0;
    end else if (wr_ok) begin
      if (cfg_addr == dpo_pkg::OFS_A_SEL) begin
        conc_ff <= cfg_wdata[dpo_pkg::BIT_CONC];
      end
      if (cfg_addr == dpo_pkg::OFS_A_LINK) begin
        chan_ff <= cfg_wdata[dpo_pkg::BIT_CHAN_MODE];
      end
      if (cfg_addr == dpo_pkg::OFS_CLK) begin
        ctl_ff <= cfg_wdata[2:0];
      end
    end
  end
  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Eight cycles cover the synchroniser only while the port clock is mclk.
  sequence s_stalled;
    (!port_a_acknowledge && port_a_parallel_active && ctl_ff == 3'h1) [*8];
  endsequence
  sequence s_ack_then_req;
    port_a_acknowledge [*4] ##0 $rose(port_a_request);
  endsequence
  a_reset_slave: assert property (
    $rose(rstn) |-> !pclk_oe)
    else $error("port clock driven right after reset");
  a_clock_write: assert property (
    wr_ok && cfg_addr == dpo_pkg::OFS_CLK |=> pclk_oe == $past(cfg_wdata[0]))
    else $error("clock direction does not follow its write");
  a_enable_write: assert property (
    wr_ok && cfg_addr == dpo_pkg::OFS_A_LINK
    |=> port_a_parallel_active == $past(cfg_wdata[7]))
    else $error("port enable does not follow its write");
  a_disabled_quiet: assert property (
    !port_a_parallel_active [*3] |-> !port_a_request && !port_a_iq_flag
    && port_a_data_bus == 16'h0000)
    else $error("disabled port still active");
  a_stall_holds: assert property (
    s_stalled |-> $stable(port_a_data_bus) && $stable(port_a_source_id))
    else $error("word shifted while acknowledge low");
  a_q_follows_i: assert property (
    $fell(port_a_iq_flag) && port_a_parallel_active && !conc_ff
    |-> $stable(port_a_source_id))
    else $error("second word from another source");
  a_signal_strength_word_word: assert property (
    port_a_parallel_active && !chan_ff && port_a_source_id[1]
    |-> !port_a_iq_flag && port_a_data_bus[3:0] == dpo_pkg::SIGNAL_STRENGTH_WORD_PAD)
    else $error("strength word badly formed");
  a_div_one: assert property (
    (ctl_ff == 3'h1) [*3] |-> pclk_out)
    else $error("divide by one clock not high");
  a_div_two: assert property (
    (ctl_ff == 3'h3) [*3] |-> pclk_out != $past(pclk_out))
    else $error("divide by two clock not toggling");
  a_req_start: assert property (
    s_ack_then_req ##0 (ctl_ff == 3'h1) |-> ##[1:4] $changed(port_a_data_bus))
    else $error("no word soon after request");
endmodule

bind dpo_top dpo_chk u_chk (
  .mclk(mclk), .rstn(rstn), .cfg_access_en(cfg_access_en),
  .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
  .pclk_out(pclk_out), .pclk_oe(pclk_oe),
  .port_a_acknowledge(port_a_acknowledge),
  .port_a_request(port_a_request), .port_a_data_bus(port_a_data_bus),
  .port_a_iq_flag(port_a_iq_flag), .port_a_source_id(port_a_source_id),
  .port_a_parallel_active(port_a_parallel_active)
);

// *** tb/dpo_sink.sv ***
`timescale 1ns/1ps
module dpo_sink (
  // Bench control
  input wire logic mclk,
  input wire logic stall,
  input wire logic run_clk,
  // Far-side pins
  output logic pclk,
  output logic acknowledge,
  input wire logic [15:0] data_bus,
  input wire logic iq_flag,
  input wire logic [1:0] source_id,
  input wire logic active
);
  // ****************************************
  // Capture of shifted words
  // ****************************************
  logic [18:0] got[$];
  logic [17:0] last = '0;
  assign acknowledge = !stall;
  // The clock stands still low unless the bench asks for it.
  initial begin
    pclk = 1'b0;
    #1;
    forever begin
      #10;
      pclk = run_clk ? !pclk : 1'b0;
    end
  end
  // A word is a change of data or id; the flag alone drops between words.
  always @(posedge mclk) begin
    if (active && {data_bus, source_id} !== last) begin
      got.push_back({data_bus, iq_flag, source_id});
    end
    last = {data_bus, source_id};
  end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  // ****************************************
  // Signals
  // ****************************************
  typedef struct {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] r;
  } dpo_row_t;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic acc = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [3:0] ch_valid = 4'h0;
  logic [63:0] ch_i = '0;
  logic [63:0] ch_q = '0;
  logic [1:0] agc_valid = 2'h0;
  logic [31:0] agc_i = '0;
  logic [31:0] agc_q = '0;
  logic [23:0] gain = '0;
  logic stall_a = 1'b0;
  logic stall_b = 1'b0;
  logic run_clk = 1'b0;
  logic [7:0] rdata;
  logic far_clk, pclk_in, pclk_out, pclk_oe, prev;
  logic a_ack, a_req, a_iq, a_act, b_ack, b_req, b_iq, b_act;
  logic [15:0] a_data, b_data;
  logic [1:0] a_id, b_id;
  int miscompares = 0;
  int n_checks = 0;
  int rises;
  dpo_row_t rows[6] = '{'{dpo_pkg::OFS_A_SEL, 8'h3e, 8'h3e},
    '{dpo_pkg::OFS_B_SEL, 8'h15, 8'h15}, '{dpo_pkg::OFS_B_LINK, 8'h7f, 8'h7f},
    '{dpo_pkg::OFS_A_LINK, 8'h81, 8'h81}, '{dpo_pkg::OFS_CLK, 8'h07, 8'h07},
    '{8'h1f, 8'h5a, 8'h00}};
  always #4 mclk = ~mclk;
  assign pclk_in = (pclk_oe === 1'b1) ? pclk_out : far_clk;
  dpo_top #(.FIFO_DEPTH(2)) dut (.mclk(mclk), .ce(ce), .rstn(rstn),
    .cfg_access_en(acc), .cfg_addr(addr), .cfg_wr(wr), .cfg_rd(rd),
    .cfg_wdata(wdata), .cfg_rdata(rdata), .ch_valid(ch_valid), .ch_i(ch_i),
    .ch_q(ch_q), .agc_valid(agc_valid), .agc_i(agc_i), .agc_q(agc_q),
    .agc_gain(gain), .pclk_in(pclk_in), .pclk_out(pclk_out),
    .pclk_oe(pclk_oe), .port_a_acknowledge(a_ack), .port_a_request(a_req),
    .port_a_data_bus(a_data), .port_a_iq_flag(a_iq), .port_a_source_id(a_id),
    .port_a_parallel_active(a_act), .port_b_acknowledge(b_ack),
    .port_b_request(b_req), .port_b_data_bus(b_data), .port_b_iq_flag(b_iq),
    .port_b_source_id(b_id), .port_b_parallel_active(b_act));
  dpo_sink pa (.mclk(mclk), .stall(stall_a), .run_clk(run_clk),
    .pclk(far_clk), .acknowledge(a_ack), .data_bus(a_data), .iq_flag(a_iq),
    .source_id(a_id), .active(a_act));
  dpo_sink pb (.mclk(mclk), .stall(stall_b), .run_clk(1'b0), .pclk(),
    .acknowledge(b_ack), .data_bus(b_data), .iq_flag(b_iq),
    .source_id(b_id), .active(b_act));
  // ****************************************
  // Tasks
  // ****************************************
  function automatic logic [15:0] smp(input int c, input int q, input int g);
    return 16'(16'h1111 * (c + 1) + 16'h0800 * q + 16'h4000 * g);
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h not %h", $time, what, got, exp);
    end
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge mclk);
    wr = 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    addr = a;
    rd = 1'b1;
    @(negedge mclk);
    rd = 1'b0;
    @(negedge mclk);
    check(rdata, exp, "register read");
  endtask
  task automatic pulse_ch(input logic [3:0] v);
    @(negedge mclk);
    ch_valid = v;
    @(negedge mclk);
    ch_valid = 4'h0;
  endtask
  task automatic agc_step(input logic [1:0] v, input logic [23:0] g,
                          input int k);
    @(negedge mclk);
    agc_i = {smp(3, 0, k), smp(2, 0, k)};
    agc_q = {smp(3, 1, k), smp(2, 1, k)};
    gain = g;
    agc_valid = v;
    @(negedge mclk);
    agc_valid = 2'h0;
  endtask
  task automatic expect_words(input int p, input logic [18:0] exp[$]);
    for (int k = 0; k < 400; k++) begin
      if ((p == 0 ? pa.got.size() : pb.got.size()) >= exp.size()) break;
      @(negedge mclk);
    end
    repeat (8) @(negedge mclk);
    check(p == 0 ? pa.got.size() : pb.got.size(), exp.size(), "word count");
    foreach (exp[k]) check(p == 0 ? pa.got[k] : pb.got[k], exp[k], "word");
    pa.got.delete();
    pb.got.delete();
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    $display("wrong value at %0t: watchdog expired", $time);
    tally_and_finish();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (20) @(negedge mclk);
    rstn = 1'b1;
    @(negedge mclk);
    check(pclk_oe, 1'b0, "clock direction after reset");
    check(a_req, 1'b0, "request after reset");
    foreach (rows[i]) rchk(rows[i].a, 8'h00);
    foreach (rows[i]) begin
      put(rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].r);
    end
    acc = 1'b0;
    put(dpo_pkg::OFS_A_LINK, 8'h00);
    acc = 1'b1;
    rchk(dpo_pkg::OFS_A_LINK, 8'h81);
    ce = 1'b0;
    put(dpo_pkg::OFS_B_LINK, 8'h00);
    ce = 1'b1;
    rchk(dpo_pkg::OFS_B_LINK, 8'h7f);
    $display("test registers finished");
    put(dpo_pkg::OFS_CLK, 8'h01);
    put(dpo_pkg::OFS_A_SEL, 8'h1e);
    put(dpo_pkg::OFS_B_SEL, 8'h34);
    stall_a = 1'b1;
    put(dpo_pkg::OFS_B_LINK, 8'h81);
    for (int c = 0; c < 4; c++) begin
      ch_i[16*c +: 16] = smp(c, 0, 0);
      ch_q[16*c +: 16] = smp(c, 1, 0);
    end
    pulse_ch(4'hf);
    expect_words(1, '{{16'h222a, 1'b1, 2'd1}, {16'h444c, 1'b1, 2'd3}});
    check(a_req, 1'b1, "request while stalled");
    ch_i[47:32] = smp(2, 0, 1);
    ch_q[47:32] = smp(2, 1, 1);
    pulse_ch(4'h4);
    stall_a = 1'b0;
    expect_words(0, '{{smp(0, 0, 0), 1'b1, 2'd0},
      {smp(0, 1, 0), 1'b0, 2'd0}, {smp(1, 0, 0), 1'b1, 2'd1},
      {smp(1, 1, 0), 1'b0, 2'd1}, {smp(2, 0, 1), 1'b1, 2'd2},
      {smp(2, 1, 1), 1'b0, 2'd2}, {smp(3, 0, 0), 1'b1, 2'd3},
      {smp(3, 1, 0), 1'b0, 2'd3}});
    check(a_req, 1'b0, "request after drain");
    stall_a = 1'b1;
    pulse_ch(4'h1);
    repeat (10) @(negedge mclk);
    put(dpo_pkg::OFS_A_LINK, 8'h00);
    repeat (3) @(negedge mclk);
    check(a_req, 1'b0, "request when disabled");
    stall_a = 1'b0;
    $display("test channel mode finished");
    put(dpo_pkg::OFS_A_SEL, 8'h06);
    put(dpo_pkg::OFS_A_LINK, 8'h80);
    agc_step(2'h3, 24'h456_123, 0);
    repeat (40) @(negedge mclk);
    pa.got.delete();
    agc_step(2'h1, 24'h456_123, 1);
    expect_words(0, '{{smp(2, 0, 1), 1'b1, 2'd0},
      {smp(2, 1, 1), 1'b0, 2'd0}});
    agc_step(2'h3, 24'h789_0f0, 2);
    expect_words(0, '{{smp(2, 0, 2), 1'b1, 2'd0},
      {smp(2, 1, 2), 1'b0, 2'd0}, {~12'h0f0, 4'h0, 1'b0, 2'd2},
      {smp(3, 0, 2), 1'b1, 2'd1}, {smp(3, 1, 2), 1'b0, 2'd1},
      {~12'h789, 4'h0, 1'b0, 2'd3}});
    put(dpo_pkg::OFS_A_SEL, 8'h04);
    agc_step(2'h3, 24'h789_0f0, 3);
    expect_words(0, '{{smp(3, 0, 3), 1'b1, 2'd1},
      {smp(3, 1, 3), 1'b0, 2'd1}});
    $display("test agc mode finished");
    put(dpo_pkg::OFS_A_LINK, 8'h00);
    for (int d = 0; d < 4; d++) begin
      put(dpo_pkg::OFS_CLK, 8'(2 * d + 1));
      repeat (4) @(negedge mclk);
      rises = 0;
      prev = pclk_out;
      repeat (64) begin
        @(negedge mclk);
        if (pclk_out && !prev) rises++;
        prev = pclk_out;
      end
      check(rises, d == 0 ? 0 : 64 >> d, "port clock rises");
    end
    put(dpo_pkg::OFS_CLK, 8'h00);
    @(negedge mclk);
    check(pclk_oe, 1'b0, "clock direction in slave mode");
    put(dpo_pkg::OFS_B_SEL, 8'h02);
    run_clk = 1'b1;
    ch_i[15:0] = smp(0, 0, 1);
    ch_q[15:0] = smp(0, 1, 1);
    pulse_ch(4'h1);
    expect_words(1, '{{smp(0, 0, 1), 1'b1, 2'd0},
      {smp(0, 1, 1), 1'b0, 2'd0}});
    check(b_req, 1'b0, "port B request after drain");
    run_clk = 1'b0;
    $display("test port clock finished");
    tally_and_finish();
  end
endmodule
